// file: verif/sync_input_coast_control_checker.sv
// Checker bound to the sync front end top module
// Assumes one clock core_clk and async active low rstn
`timescale 1ns/1ps
`default_nettype none
`include "sync_input_coast_control_defs.svh"

module sync_input_coast_control_checker #(
  parameter int VSEP_CYCLES = 250,
  parameter int VSEP_CNT_W = 9
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic horizontal_timing_in_0,
  input wire logic horizontal_timing_in_1,
  input wire logic green_embedded_timing_in_0,
  input wire logic green_embedded_timing_in_1,
  input wire logic hold_or_external_clock_pin,
  input wire logic embedded_timing_comparator_out,
  input wire logic [5:0] threshold_code,
  input wire logic pll_hold,
  input wire logic pll_track_pulse,
  input wire logic clock_source_external,
  input wire logic external_sample_clock
);
  // ----------------------------------------
  // Configuration mirror
  // ----------------------------------------
  logic done, ok, hs, sog, hpol_r, kpol_r;
  logic [2:0] sel_r, quiet_r;
  assign done = write && !waitrequest && byteenable[0];
  assign ok = quiet_r == 3'h7;
  assign hs = sel_r[0] ? horizontal_timing_in_1 : horizontal_timing_in_0;
  assign sog = sel_r[0] ? green_embedded_timing_in_1 :
    green_embedded_timing_in_0;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hpol_r <= 1'b0;
      kpol_r <= 1'b1;
      sel_r <= 3'h0;
      quiet_r <= 3'h0;
    end else begin
      quiet_r <= done ? 3'h0 : (ok ? quiet_r : quiet_r + 3'h1);
      if (done && address == `REG_HSYNC_CFG_ADDR) hpol_r <= writedata[4];
      if (done && address == `REG_HOLD_CFG_ADDR) kpol_r <= writedata[5];
      if (done && address == `REG_SYNC_SEL_ADDR) sel_r <= writedata[2:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_bus_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus wait too long");
  a_hold_level: assert property (
    ok |-> pll_hold == ($past(hold_or_external_clock_pin, 2) == kpol_r))
    else $error("hold level wrong");
  a_hold_blocks: assert property (
    pll_hold && $past(pll_hold) && $past(pll_hold, 2) |-> !pll_track_pulse)
    else $error("track pulse during hold");
  a_lead_edge: assert property (
    ok && !sel_r[1] && hs != $past(hs) && hs == hpol_r && !pll_hold
    ##1 !pll_hold ##1 !pll_hold |-> pll_track_pulse)
    else $error("leading edge lost");
  a_pulse_cause: assert property (
    ok && !sel_r[1] && pll_track_pulse |->
    $past(hs, 2) == hpol_r && $past(hs, 3) != hpol_r)
    else $error("track pulse without leading edge");
  a_comp_copy: assert property (
    ok |-> embedded_timing_comparator_out == $past(sog, 2))
    else $error("comparator output wrong");
  a_thresh_range: assert property (
    threshold_code >= `THRESH_MIN_CODE && threshold_code <= `THRESH_MAX_CODE)
    else $error("threshold out of range");
  a_thresh_reset: assert property (
    !$past(rstn) |-> threshold_code == `THRESH_RST_CODE)
    else $error("threshold reset wrong");
  a_ext_copy: assert property (
    external_sample_clock ==
    ($past(clock_source_external) &&
     $past(hold_or_external_clock_pin, 2)))
    else $error("external clock copy wrong");
endmodule : sync_input_coast_control_checker

bind sync_input_coast_control sync_input_coast_control_checker #(
  .VSEP_CYCLES(VSEP_CYCLES), .VSEP_CNT_W(VSEP_CNT_W)
) chk_i (
  .core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest),
  .horizontal_timing_in_0(horizontal_timing_in_0),
  .horizontal_timing_in_1(horizontal_timing_in_1),
  .green_embedded_timing_in_0(green_embedded_timing_in_0),
  .green_embedded_timing_in_1(green_embedded_timing_in_1),
  .hold_or_external_clock_pin(hold_or_external_clock_pin),
  .embedded_timing_comparator_out(embedded_timing_comparator_out),
  .threshold_code(threshold_code), .pll_hold(pll_hold),
  .pll_track_pulse(pll_track_pulse),
  .clock_source_external(clock_source_external),
  .external_sample_clock(external_sample_clock)
);

`default_nettype wire

// file: verif/tb_sync_input_coast_control.sv
// Self-checking bench for the sync front end
// Assumes the source model drives every sync and hold pin
`timescale 1ns/1ps
`default_nettype none

module tb_sync_input_coast_control;
  logic core_clk, rstn, read, write, waitrequest, comp_out, pll_hold;
  logic pll_track_pulse, vert_out, cse, esc;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [6:0] pins;
  logic [5:0] threshold_code;
  int bad_count, compares, pulses, p0;

  video_source_model src (.core_clk(core_clk), .pins(pins));
  sync_input_coast_control #(.VSEP_CYCLES(8), .VSEP_CNT_W(4)) uut (
    .core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .horizontal_timing_in_0(pins[0]), .horizontal_timing_in_1(pins[1]),
    .vertical_timing_in_0(pins[2]), .vertical_timing_in_1(pins[3]),
    .green_embedded_timing_in_0(pins[4]),
    .green_embedded_timing_in_1(pins[5]),
    .hold_or_external_clock_pin(pins[6]),
    .embedded_timing_comparator_out(comp_out),
    .threshold_code(threshold_code), .pll_hold(pll_hold),
    .pll_track_pulse(pll_track_pulse), .vertical_timing_out(vert_out),
    .clock_source_external(cse), .external_sample_clock(esc));

  // ----------------------------------------
  // Clock, pulse count, checks and bus cycles
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    if (pll_track_pulse === 1'b1) pulses <= pulses + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge core_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    q = readdata;
    if (n == 20) chk(waitrequest, 32'h0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic t_regs;
    bus(0, 8'h60, 0);
    chk(q, 32'h20);
    byteenable <= 4'h0;
    bus(1, 8'hc4, 32'h05);
    byteenable <= 4'h1;
    bus(0, 8'hc4, 0);
    chk(q, 32'h0f);
    bus(0, 8'h04, 0);
    chk(q, 32'h0);
    bus(1, 8'hc4, 32'h00);
    bus(0, 8'hc4, 0);
    chk(q, 32'h01);
    bus(1, 8'hc4, 32'h3f);
    bus(0, 8'hc4, 0);
    chk(q, 32'h21);
    chk(threshold_code, 6'h21);
    bus(1, 8'hc4, 32'h1e);
    bus(0, 8'hc4, 0);
    chk(q, 32'h1e);
    chk(threshold_code, 6'h1e);
    $display("regs test ended");
  endtask : t_regs
  task automatic t_hold;
    src.setp(6, 1'b1);
    repeat (3) @(posedge core_clk);
    chk(pll_hold, 1);
    p0 = pulses;
    src.flip(0, 3);
    chk(pulses - p0, 0);
    bus(0, 8'hc8, 0);
    chk(q[0], 1);
    bus(1, 8'h60, 32'h00);
    src.strap(1'b0);
    repeat (3) @(posedge core_clk);
    chk(pll_hold, 0);
    bus(1, 8'hc0, 32'h04);
    src.setp(6, 1'b0);
    repeat (3) @(posedge core_clk);
    chk(pll_hold, 1);
    chk(cse, 1);
    src.setp(6, 1'b1);
    repeat (3) @(posedge core_clk);
    chk(esc, 1);
    chk(pll_hold, 0);
    bus(1, 8'hc0, 32'h00);
    bus(1, 8'h60, 32'h20);
    src.strap(1'b1);
    $display("hold test ended");
  endtask : t_hold
  task automatic t_sync;
    p0 = pulses;
    src.flip(0, 3);
    chk(pulses - p0, 1);
    bus(1, 8'h48, 32'h10);
    bus(1, 8'hc0, 32'h01);
    p0 = pulses;
    src.flip(0, 3);
    chk(pulses - p0, 0);
    src.flip(1, 3);
    chk(pulses - p0, 1);
    src.setp(3, 1'b1);
    src.setp(5, 1'b0);
    repeat (4) @(posedge core_clk);
    chk(vert_out, 1);
    chk(comp_out, 0);
    src.setp(3, 1'b0);
    src.setp(5, 1'b1);
    src.setp(4, 1'b0);
    repeat (4) @(posedge core_clk);
    chk(vert_out, 0);
    chk(comp_out, 1);
    src.setp(4, 1'b1);
    bus(1, 8'h48, 32'h00);
    $display("sync test ended");
  endtask : t_sync
  task automatic t_embed;
    bus(1, 8'hc0, 32'h02);
    p0 = pulses;
    src.flip(4, 3);
    chk(pulses - p0, 1);
    chk(vert_out, 0);
    src.setp(4, 1'b0);
    repeat (14) @(posedge core_clk);
    chk(vert_out, 1);
    src.setp(4, 1'b1);
    repeat (14) @(posedge core_clk);
    chk(vert_out, 0);
    $display("embedded test ended");
  endtask : t_embed
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h1;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_hold();
    t_sync();
    t_embed();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
endmodule : tb_sync_input_coast_control

`default_nettype wire

// file: verif/video_source_model.sv
// Video source model driving the sync, embedded and hold pins
// Assumes bench calls its tasks; pins change after core_clk rises
`timescale 1ns/1ps
`default_nettype none

module video_source_model (
  input wire logic core_clk,
  output logic [6:0] pins
);
  // ----------------------------------------
  // Pins: 0,1 hsync 2,3 vsync 4,5 embedded 6 hold
  // ----------------------------------------
  initial begin
    pins = 7'h30;
  end
  task automatic setp(input int i, input logic v);
    @(posedge core_clk);
    pins[i] <= v;
  endtask : setp
  task automatic flip(input int i, input int len);
    @(posedge core_clk);
    pins[i] <= !pins[i];
    repeat (len) @(posedge core_clk);
    pins[i] <= !pins[i];
    repeat (6) @(posedge core_clk);
  endtask : flip
  task automatic strap(input logic pol);
    setp(6, !pol);
  endtask : strap
endmodule : video_source_model

`default_nettype wire

// file: verilog/composite_sync_separator.sv
// Splits composite sync into horizontal leading edges and vertical
// Assumes csync_act is synchronous to core_clk and active high
`timescale 1ns/1ps
`default_nettype none
`include "sync_input_coast_control_defs.svh"

module composite_sync_separator #(
  parameter int VSEP_CYCLES = `VSEP_CYCLES,
  parameter int CNT_W = 9
) (
  input wire logic core_clk,
  input wire logic rstn,
  sync_sep_if.sep bus
);

  sync_input_coast_control_pkg::sep_state_e state_r;
  sync_input_coast_control_pkg::sep_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic h_lead_r;
  logic h_lead_nxt;
  logic vert_r;
  logic vert_nxt;
  logic cnt_end;

  assign cnt_end = (cnt_r == CNT_W'(VSEP_CYCLES - 1));

  // ----------------------------------------
  // Pulse width classifier
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    h_lead_nxt = 1'b0;
    case (state_r)
      sync_input_coast_control_pkg::SEP_IDLE: begin
        if (bus.csync_act) begin
          state_nxt = sync_input_coast_control_pkg::SEP_PULSE;
          cnt_nxt = '0;
          h_lead_nxt = 1'b1;
        end
      end
      sync_input_coast_control_pkg::SEP_PULSE: begin
        if (!bus.csync_act) begin
          state_nxt = sync_input_coast_control_pkg::SEP_IDLE;
        end else if (cnt_end) begin
          state_nxt = sync_input_coast_control_pkg::SEP_VERT;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      sync_input_coast_control_pkg::SEP_VERT: begin
        if (!bus.csync_act) begin
          state_nxt = sync_input_coast_control_pkg::SEP_GAP;
          cnt_nxt = '0;
        end
      end
      sync_input_coast_control_pkg::SEP_GAP: begin
        if (bus.csync_act) begin
          state_nxt = sync_input_coast_control_pkg::SEP_VERT;
        end else if (cnt_end) begin
          state_nxt = sync_input_coast_control_pkg::SEP_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = sync_input_coast_control_pkg::SEP_IDLE;
        cnt_nxt = '0;
      end
    endcase
    vert_nxt = (state_nxt == sync_input_coast_control_pkg::SEP_VERT) ||
               (state_nxt == sync_input_coast_control_pkg::SEP_GAP);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= sync_input_coast_control_pkg::SEP_IDLE;
      cnt_r <= '0;
      h_lead_r <= 1'b0;
      vert_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      h_lead_r <= h_lead_nxt;
      vert_r <= vert_nxt;
    end
  end

  assign bus.h_lead = h_lead_r;
  assign bus.vert_act = vert_r;

endmodule : composite_sync_separator

`default_nettype wire

// file: verilog/sync_input_coast_control.sv
// Sync input front end with hold and external clock control
// Assumes all pins synchronous to core_clk; Avalon-MM slave for config
`timescale 1ns/1ps
`default_nettype none
`include "sync_input_coast_control_defs.svh"

module sync_input_coast_control #(
  parameter int VSEP_CYCLES = `VSEP_CYCLES,
  parameter int VSEP_CNT_W = 9
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic horizontal_timing_in_0,
  input wire logic horizontal_timing_in_1,
  input wire logic vertical_timing_in_0,
  input wire logic vertical_timing_in_1,
  input wire logic green_embedded_timing_in_0,
  input wire logic green_embedded_timing_in_1,
  input wire logic hold_or_external_clock_pin,
  output logic embedded_timing_comparator_out,
  output logic [5:0] threshold_code,
  output logic pll_hold,
  output logic pll_track_pulse,
  output logic vertical_timing_out,
  output logic clock_source_external,
  output logic external_sample_clock
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  function automatic logic [5:0] clamp_thr(input logic [5:0] v);
    if (v < `THRESH_MIN_CODE) begin
      clamp_thr = `THRESH_MIN_CODE;
    end else if (v > `THRESH_MAX_CODE) begin
      clamp_thr = `THRESH_MAX_CODE;
    end else begin
      clamp_thr = v;
    end
  endfunction : clamp_thr

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_fire;
  logic [31:0] rd_mux;

  logic [1:0] hpol_r;
  logic [1:0] hpol_nxt;
  logic [1:0] cpol_r;
  logic [1:0] cpol_nxt;
  logic [2:0] sel_r;
  logic [2:0] sel_nxt;
  logic [5:0] thr_r;
  logic [5:0] thr_nxt;

  logic hold_act_r;
  logic vert_r;
  logic cmp_out_r;
  logic ext_clk_r;

  assign waitrequest = (read | write) & ~ack_r;
  assign wr_fire = write & ack_r & byteenable[0];

  always_comb begin
    rd_mux = 32'h0;
    if (hit(address, `REG_HSYNC_CFG_ADDR)) begin
      rd_mux[`HSYNC_POL_LSB +: 2] = hpol_r;
    end else if (hit(address, `REG_HOLD_CFG_ADDR)) begin
      rd_mux[`HOLD_POL_LSB +: 2] = cpol_r;
    end else if (hit(address, `REG_SYNC_SEL_ADDR)) begin
      rd_mux[2:0] = sel_r;
    end else if (hit(address, `REG_THRESH_ADDR)) begin
      rd_mux[5:0] = thr_r;
    end else if (hit(address, `REG_STATUS_ADDR)) begin
      rd_mux[3:0] = {ext_clk_r, cmp_out_r, vert_r, hold_act_r};
    end
  end

  always_comb begin
    ack_nxt = (read | write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (read & ~ack_r) begin
      rdata_nxt = rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign readdata = rdata_r;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_comb begin
    hpol_nxt = hpol_r;
    cpol_nxt = cpol_r;
    sel_nxt = sel_r;
    thr_nxt = thr_r;
    if (wr_fire && hit(address, `REG_HSYNC_CFG_ADDR)) begin
      hpol_nxt = writedata[`HSYNC_POL_LSB +: 2];
    end
    if (wr_fire && hit(address, `REG_HOLD_CFG_ADDR)) begin
      cpol_nxt = writedata[`HOLD_POL_LSB +: 2];
    end
    if (wr_fire && hit(address, `REG_SYNC_SEL_ADDR)) begin
      sel_nxt = writedata[2:0];
    end
    if (wr_fire && hit(address, `REG_THRESH_ADDR)) begin
      thr_nxt = clamp_thr(writedata[5:0]);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hpol_r <= `HSYNC_POL_RST;
      cpol_r <= `HOLD_POL_RST;
      sel_r <= `SYNC_SEL_RST;
      thr_r <= `THRESH_RST_CODE;
    end else begin
      hpol_r <= hpol_nxt;
      cpol_r <= cpol_nxt;
      sel_r <= sel_nxt;
      thr_r <= thr_nxt;
    end
  end

  assign threshold_code = thr_r;
  assign clock_source_external = sel_r[`SEL_EXTERNAL_SAMPLE_CLOCK_BIT];

  // ----------------------------------------
  // Input sampling and channel select
  // ----------------------------------------
  logic chan;
  logic embed;
  logic hs_sel;
  logic vs_sel;
  logic cmp_sel;
  logic hs_r;
  logic hs_prev_r;
  logic vs_r;
  logic cmp_r;
  logic pin_r;

  assign chan = sel_r[`SEL_CHAN_BIT];
  assign embed = sel_r[`SEL_EMBED_BIT];
  assign hs_sel = chan ? horizontal_timing_in_1 :
                         horizontal_timing_in_0;
  assign vs_sel = chan ? vertical_timing_in_1 :
                         vertical_timing_in_0;
  assign cmp_sel = chan ? green_embedded_timing_in_1 :
                          green_embedded_timing_in_0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hs_r <= 1'b0;
      hs_prev_r <= 1'b0;
      vs_r <= 1'b0;
      cmp_r <= 1'b1;
      pin_r <= 1'b0;
    end else begin
      hs_r <= hs_sel;
      hs_prev_r <= hs_r;
      vs_r <= vs_sel;
      cmp_r <= cmp_sel;
      pin_r <= hold_or_external_clock_pin;
    end
  end

  // ----------------------------------------
  // Composite separator
  // ----------------------------------------
  sync_sep_if sep_bus ();

  assign sep_bus.csync_act = embed & ~cmp_r;

  composite_sync_separator #(
    .VSEP_CYCLES(VSEP_CYCLES),
    .CNT_W(VSEP_CNT_W)
  ) u_sep (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus(sep_bus.sep)
  );

  // ----------------------------------------
  // Edge, hold and output logic
  // ----------------------------------------
  logic hs_lead;
  logic h_edge;
  logic hold_act;
  logic track_r;
  logic track_nxt;
  logic hold_nxt;
  logic vert_nxt;
  logic cmp_out_nxt;
  logic ext_clk_nxt;

  always_comb begin
    if (hpol_r[0]) begin
      hs_lead = hs_r & ~hs_prev_r;
    end else begin
      hs_lead = ~hs_r & hs_prev_r;
    end
    h_edge = embed ? sep_bus.h_lead : hs_lead;
    hold_act = cpol_r[0] ? pin_r : ~pin_r;
    hold_nxt = hold_act;
    track_nxt = h_edge & ~hold_act;
    vert_nxt = embed ? sep_bus.vert_act : vs_r;
    cmp_out_nxt = cmp_r;
    ext_clk_nxt = pin_r & sel_r[`SEL_EXTERNAL_SAMPLE_CLOCK_BIT];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      track_r <= 1'b0;
      hold_act_r <= 1'b0;
      vert_r <= 1'b0;
      cmp_out_r <= 1'b1;
      ext_clk_r <= 1'b0;
    end else begin
      track_r <= track_nxt;
      hold_act_r <= hold_nxt;
      vert_r <= vert_nxt;
      cmp_out_r <= cmp_out_nxt;
      ext_clk_r <= ext_clk_nxt;
    end
  end

  assign pll_track_pulse = track_r;
  assign pll_hold = hold_act_r;
  assign vertical_timing_out = vert_r;
  assign embedded_timing_comparator_out = cmp_out_r;
  assign external_sample_clock = ext_clk_r;

endmodule : sync_input_coast_control

`default_nettype wire

// file: verilog/sync_input_coast_control_defs.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the separator, the top module and the checker
`ifndef SYNC_INPUT_COAST_CONTROL_DEFS_SVH
`define SYNC_INPUT_COAST_CONTROL_DEFS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define REG_HSYNC_CFG_IDX 6'h12
`define REG_HOLD_CFG_IDX 6'h18
`define REG_SYNC_SEL_IDX 6'h30
`define REG_THRESH_IDX 6'h31
`define REG_STATUS_IDX 6'h32
`define REG_HSYNC_CFG_ADDR ({`REG_HSYNC_CFG_IDX, 2'b00})
`define REG_HOLD_CFG_ADDR ({`REG_HOLD_CFG_IDX, 2'b00})
`define REG_SYNC_SEL_ADDR ({`REG_SYNC_SEL_IDX, 2'b00})
`define REG_THRESH_ADDR ({`REG_THRESH_IDX, 2'b00})
`define REG_STATUS_ADDR ({`REG_STATUS_IDX, 2'b00})

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HSYNC_POL_LSB 4
`define HOLD_POL_LSB 5
`define SEL_CHAN_BIT 0
`define SEL_EMBED_BIT 1
`define SEL_EXTERNAL_SAMPLE_CLOCK_BIT 2

// ----------------------------------------
// Reset values, threshold step and limits
// ----------------------------------------
`define HSYNC_POL_RST 2'h0
`define HOLD_POL_RST 2'h1
`define SYNC_SEL_RST 3'h0
`define THRESH_STEP_MV 10
`define THRESH_MIN_CODE 6'h01
`define THRESH_MAX_CODE 6'h21
`define THRESH_RST_CODE 6'h0f

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define VSEP_TIME_NS 10000
`define VSEP_CYCLES \
  ((`VSEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: verilog/sync_input_coast_control_pkg.sv
// Types shared by the sync front end
// Assumes the defs header supplies all numbers
package sync_input_coast_control_pkg;

  typedef enum logic [1:0] {
    SEP_IDLE,
    SEP_PULSE,
    SEP_VERT,
    SEP_GAP
  } sep_state_e;

endpackage : sync_input_coast_control_pkg

// file: verilog/sync_sep_if.sv
// Carrier between the front end and the composite separator
// Assumes one clock domain, core_clk
`timescale 1ns/1ps
`default_nettype none

interface sync_sep_if;
  logic csync_act;
  logic h_lead;
  logic vert_act;

  modport src (
    output csync_act,
    input h_lead,
    input vert_act
  );

  modport sep (
    input csync_act,
    output h_lead,
    output vert_act
  );
endinterface : sync_sep_if

`default_nettype wire
